// *** core/eisp_sequencer.sv ***
// Serial test-port programming sequencer with a small EEPROM array.
`include "eisp_defs.svh"

module eisp_sequencer #(
  parameter logic [`EISP_DR_W-1:0] ID_CODE = `EISP_ID_CODE, // Arbitrary value.
  parameter int MODE_CYC = `EISP_MODE_US * `EISP_CLK_MHZ,
  parameter int ERASE_CYC = `EISP_ERASE_US * `EISP_CLK_MHZ,
  parameter int PROG_CYC = `EISP_PROG_US * `EISP_CLK_MHZ,
  parameter int READ_CYC = `EISP_READ_US * `EISP_CLK_MHZ
) (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Async reset.
  input wire logic tck, // Test clock.
  input wire logic tms, // Test mode select.
  input wire logic tdi, // Serial in.
  output logic tdo, // Serial out.
  output logic tdo_oe, // Serial out enable.
  input wire logic [`EISP_IO_W-1:0] user_out, // User pin data.
  input wire logic [`EISP_IO_W-1:0] user_oe, // User pin enables.
  output eisp_pkg::eisp_pin_type pad, // Pad drive.
  output logic isp_active // Programming mode.
);
  import eisp_pkg::*;

  // ----------------------------------------
  // Test-port state machine
  // ----------------------------------------

  // Standard next-state table of the test port.
  function automatic eisp_tap_type tap_next(
    input eisp_tap_type s,
    input logic m
  );
    case (s)
      T_RESET: tap_next = m ? T_RESET : T_IDLE;
      T_IDLE: tap_next = m ? T_SEL_DR : T_IDLE;
      T_SEL_DR: tap_next = m ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
      T_SH_DR: tap_next = m ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: tap_next = m ? T_UP_DR : T_PA_DR;
      T_PA_DR: tap_next = m ? T_EX2_DR : T_PA_DR;
      T_EX2_DR: tap_next = m ? T_UP_DR : T_SH_DR;
      T_UP_DR: tap_next = m ? T_SEL_DR : T_IDLE;
      T_SEL_IR: tap_next = m ? T_RESET : T_CAP_IR;
      T_CAP_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
      T_SH_IR: tap_next = m ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: tap_next = m ? T_UP_IR : T_PA_IR;
      T_PA_IR: tap_next = m ? T_EX2_IR : T_PA_IR;
      T_EX2_IR: tap_next = m ? T_UP_IR : T_SH_IR;
      default: tap_next = m ? T_SEL_DR : T_IDLE;
    endcase
  endfunction

  eisp_tap_type tap_ff, nxt_tap;
  logic [`EISP_IR_W-1:0] ir_ff, nxt_ir, irs_ff, nxt_irs;
  logic [`EISP_DR_W-1:0] dr_ff, nxt_dr;
  eisp_cmd_type cmd_ff, nxt_cmd;
  logic req_ff, nxt_req;
  logic ack_s1_ff, ack_s2_ff;
  logic busy;
  logic ack_ff;
  logic [`EISP_DW-1:0] rd_ff;

  // A new command is refused while the core still owns the last one.
  assign busy = req_ff != ack_s2_ff;

  // Link-side next values: state, registers, command launch.
  always_comb begin
    nxt_tap = tap_next(tap_ff, tms);
    nxt_ir = ir_ff;
    nxt_irs = irs_ff;
    nxt_dr = dr_ff;
    nxt_cmd = cmd_ff;
    nxt_req = req_ff;
    case (tap_ff)
      T_RESET: begin
        nxt_ir = `EISP_IR_IDCODE;
      end
      T_CAP_IR: begin
        nxt_irs = `EISP_IR_CAPT;
      end
      T_SH_IR: begin
        nxt_irs = {tdi, irs_ff[`EISP_IR_W-1:1]};
      end
      T_UP_IR: begin
        nxt_ir = irs_ff;
        if (!busy) begin
          nxt_cmd.op = OP_NONE;
          if (irs_ff == `EISP_IR_ENTER) begin
            nxt_cmd.op = OP_ENTER;
          end else if (irs_ff == `EISP_IR_EXIT) begin
            nxt_cmd.op = OP_EXIT;
          end else if (irs_ff == `EISP_IR_ERASE) begin
            nxt_cmd.op = OP_ERASE;
          end
          nxt_req = (nxt_cmd.op != OP_NONE) ? ~req_ff : req_ff;
        end
      end
      T_CAP_DR: begin
        if (ir_ff == `EISP_IR_IDCODE) begin
          nxt_dr = ID_CODE;
        end else if (ir_ff == `EISP_IR_VERIFY) begin
          // Readback is only stable once the core has answered.
          nxt_dr = {8'h00, cmd_ff.addr, busy ? 16'h0000 : rd_ff};
        end else if (ir_ff != `EISP_IR_PROG) begin
          nxt_dr = 32'h0000_0000;
        end
      end
      T_SH_DR: begin
        nxt_dr = dr_ff >> 1;
        if (ir_ff == `EISP_IR_IDCODE) begin
          nxt_dr[`EISP_DR_W-1] = tdi;
        end else if (ir_ff == `EISP_IR_PROG || ir_ff == `EISP_IR_VERIFY) begin
          nxt_dr[`EISP_PD_W-1] = tdi;
        end else begin
          nxt_dr[0] = tdi;
        end
      end
      T_UP_DR: begin
        if (!busy && (ir_ff == `EISP_IR_PROG || ir_ff == `EISP_IR_VERIFY)) begin
          nxt_cmd.op = (ir_ff == `EISP_IR_PROG) ? OP_PROG : OP_READ;
          nxt_cmd.addr = dr_ff[`EISP_PD_W-1:`EISP_DW];
          nxt_cmd.data = dr_ff[`EISP_DW-1:0];
          nxt_req = ~req_ff;
        end
      end
      default: begin
        nxt_dr = dr_ff;
      end
    endcase
  end

  // Link-side registers, all on the test clock.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tap_ff <= T_RESET;
      ir_ff <= `EISP_IR_IDCODE;
      irs_ff <= `EISP_IR_CAPT;
      dr_ff <= 32'h0000_0000;
      cmd_ff <= '0;
      req_ff <= 1'b0;
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      ir_ff <= nxt_ir;
      irs_ff <= nxt_irs;
      dr_ff <= nxt_dr;
      cmd_ff <= nxt_cmd;
      req_ff <= nxt_req;
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // Serial out changes on the falling edge so the host samples it clean.
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= (tap_ff == T_SH_IR) ? irs_ff[0] : dr_ff[0];
      tdo_oe <= (tap_ff == T_SH_IR) || (tap_ff == T_SH_DR);
    end
  end

  // ----------------------------------------
  // Core-side sequencer
  // ----------------------------------------

  eisp_cst_type cst_ff, nxt_cst;
  logic [`EISP_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic req_s1_ff, req_s2_ff, seen_ff, nxt_seen;
  logic nxt_ack;
  logic mode_ok_ff, nxt_mode_ok;
  logic pins_isp_ff, nxt_pins_isp;
  logic [`EISP_DW-1:0] nxt_rd;
  logic wr_en, erase_en;
  logic start;
  logic [`EISP_DW-1:0] mem [0:(1<<`EISP_AW)-1];

  function automatic logic [`EISP_CNT_W-1:0] cyc(input int n);
    cyc = `EISP_CNT_W'(n - 1);
  endfunction

  // The command word is held steady by the link side until acknowledged.
  assign start = req_s2_ff != seen_ff;

  // Core next values: pulse timing and mode control.
  always_comb begin
    nxt_cst = cst_ff;
    nxt_cnt = cnt_ff;
    nxt_seen = seen_ff;
    nxt_ack = ack_ff;
    nxt_mode_ok = mode_ok_ff;
    nxt_pins_isp = pins_isp_ff;
    nxt_rd = rd_ff;
    wr_en = 1'b0;
    erase_en = 1'b0;
    case (cst_ff)
      C_IDLE: begin
        if (start) begin
          nxt_seen = req_s2_ff;
          nxt_ack = ~ack_ff;
          if (cmd_ff.op == OP_ENTER && !pins_isp_ff) begin
            nxt_pins_isp = 1'b1;
            nxt_cst = C_ENTER;
            nxt_cnt = cyc(MODE_CYC);
            nxt_ack = ack_ff;
          end else if (cmd_ff.op == OP_EXIT && mode_ok_ff) begin
            nxt_mode_ok = 1'b0;
            nxt_cst = C_EXIT;
            nxt_cnt = cyc(MODE_CYC);
            nxt_ack = ack_ff;
          end else if (mode_ok_ff && cmd_ff.op == OP_ERASE) begin
            nxt_cst = C_ERASE;
            nxt_cnt = cyc(ERASE_CYC);
            nxt_ack = ack_ff;
          end else if (mode_ok_ff && cmd_ff.op == OP_PROG) begin
            nxt_cst = C_PROG;
            nxt_cnt = cyc(PROG_CYC);
            nxt_ack = ack_ff;
          end else if (mode_ok_ff && cmd_ff.op == OP_READ) begin
            nxt_cst = C_READ;
            nxt_cnt = cyc(READ_CYC);
            nxt_ack = ack_ff;
          end
        end
      end
      default: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_cst = C_IDLE;
          nxt_ack = ~ack_ff;
          case (cst_ff)
            C_ENTER: nxt_mode_ok = 1'b1;
            C_EXIT: nxt_pins_isp = 1'b0;
            C_ERASE: erase_en = 1'b1;
            C_PROG: wr_en = 1'b1;
            C_READ: nxt_rd = mem[cmd_ff.addr];
            default: nxt_ack = ~ack_ff;
          endcase
        end
      end
    endcase
  end

  // Core registers; the request toggle passes two flops first.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cst_ff <= C_IDLE;
      cnt_ff <= '0;
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      seen_ff <= 1'b0;
      ack_ff <= 1'b0;
      mode_ok_ff <= 1'b0;
      pins_isp_ff <= 1'b0;
      rd_ff <= '0;
      pad <= '0;
    end else begin
      cst_ff <= nxt_cst;
      cnt_ff <= nxt_cnt;
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      seen_ff <= nxt_seen;
      ack_ff <= nxt_ack;
      mode_ok_ff <= nxt_mode_ok;
      pins_isp_ff <= nxt_pins_isp;
      rd_ff <= nxt_rd;
      // One flop per pad field so all switch on the same edge.
      pad.out <= user_out;
      pad.oe <= nxt_pins_isp ? '0 : user_oe;
      pad.pull <= nxt_pins_isp ? '1 : '0;
    end
  end

  // Erased cells read as all ones, as EEPROM does.
  always_ff @(posedge core_clk) begin
    if (erase_en) begin
      for (int i = 0; i < (1 << `EISP_AW); i++) begin
        mem[i] <= '1;
      end
    end else if (wr_en) begin
      mem[cmd_ff.addr] <= cmd_ff.data;
    end
  end

  assign isp_active = pins_isp_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  sequence s_five_ones;
    tms [*5];
  endsequence

  AST_TAP_RESET: assert property (
    @(posedge tck) disable iff (!rst_n) s_five_ones |=> tap_ff == T_RESET)
    else $error("five TMS ones did not reset the port");
  AST_SHIFT_IN: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap_ff == T_SH_IR |=> irs_ff[`EISP_IR_W-1] == $past(tdi))
    else $error("TDI bit not captured");
  AST_IDCODE: assert property (
    @(posedge tck) disable iff (!rst_n)
    tap_ff == T_CAP_DR && ir_ff == `EISP_IR_IDCODE |=> dr_ff == ID_CODE)
    else $error("identity not loaded");
  AST_PINS_HIZ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pins_isp_ff |-> pad.oe == '0 && pad.pull == '1)
    else $error("pins not floated in programming mode");
  AST_ENTER: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(pins_isp_ff) |-> !mode_ok_ff && cnt_ff == cyc(MODE_CYC))
    else $error("enter settle not started");
  AST_GATED: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cst_ff == C_IDLE && start && !mode_ok_ff |=> cst_ff inside {C_IDLE, C_ENTER})
    else $error("array operation outside programming mode");
  AST_ERASE_LEN: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(cst_ff == C_ERASE) |-> cnt_ff == cyc(ERASE_CYC))
    else $error("erase pulse length wrong");
  AST_PROG_WR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_en |=> mem[$past(cmd_ff.addr)] == $past(cmd_ff.data))
    else $error("program pulse did not write");
  AST_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cst_ff == C_READ && cnt_ff == '0 |=> rd_ff == mem[cmd_ff.addr])
    else $error("read pulse returned wrong data");
  AST_EXIT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cst_ff == C_EXIT && cnt_ff == '0 |=> !pins_isp_ff && cst_ff == C_IDLE)
    else $error("exit did not restore pins");
  AST_TDO_OE: assert property (
    @(posedge tck) disable iff (!rst_n)
    tdo_oe == (tap_ff == T_SH_DR || tap_ff == T_SH_IR))
    else $error("serial out enable does not follow the shift states");
endmodule

// *** common/eisp_defs.svh ***
// Constants for the serial in-system programming sequencer.
`ifndef EISP_DEFS_SVH
`define EISP_DEFS_SVH
`define EISP_AW 8
`define EISP_DW 16
`define EISP_IO_W 8
`define EISP_IR_W 4
`define EISP_DR_W 32
`define EISP_PD_W 24
`define EISP_CNT_W 25
`define EISP_IR_CAPT 4'h1
`define EISP_IR_IDCODE 4'h1
`define EISP_IR_ENTER 4'h2
`define EISP_IR_EXIT 4'h3
`define EISP_IR_ERASE 4'h4
`define EISP_IR_PROG 4'h5
`define EISP_IR_VERIFY 4'h6
`define EISP_IR_BYPASS 4'hf
`define EISP_CLK_MHZ 250
`define EISP_MODE_US 1000
`define EISP_ERASE_US 100000
`define EISP_PROG_US 100
`define EISP_READ_US 1
`define EISP_ID_CODE 32'h0000_5a01
`endif

// *** common/eisp_pkg.sv ***
// Types shared by the serial in-system programming sequencer.
`include "eisp_defs.svh"
package eisp_pkg;
  typedef enum logic [3:0] {
    T_RESET = 4'h0, T_IDLE = 4'h1, T_SEL_DR = 4'h2, T_CAP_DR = 4'h3,
    T_SH_DR = 4'h4, T_EX1_DR = 4'h5, T_PA_DR = 4'h6, T_EX2_DR = 4'h7,
    T_UP_DR = 4'h8, T_SEL_IR = 4'h9, T_CAP_IR = 4'ha, T_SH_IR = 4'hb,
    T_EX1_IR = 4'hc, T_PA_IR = 4'hd, T_EX2_IR = 4'he, T_UP_IR = 4'hf
  } eisp_tap_type;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_ENTER = 3'h1, OP_EXIT = 3'h2,
    OP_ERASE = 3'h3, OP_PROG = 3'h4, OP_READ = 3'h5
  } eisp_op_type;
  typedef enum logic [2:0] {
    C_IDLE = 3'h0, C_ENTER = 3'h1, C_EXIT = 3'h2,
    C_ERASE = 3'h3, C_PROG = 3'h4, C_READ = 3'h5
  } eisp_cst_type;
  typedef struct packed {
    eisp_op_type op;
    logic [`EISP_AW-1:0] addr;
    logic [`EISP_DW-1:0] data;
  } eisp_cmd_type;
  typedef struct packed {
    logic [`EISP_IO_W-1:0] out;
    logic [`EISP_IO_W-1:0] oe;
    logic [`EISP_IO_W-1:0] pull;
  } eisp_pin_type;
endpackage

// *** verification/eisp_host.sv ***
// Test-port host model that drives the serial side of the sequencer.
module eisp_host (
  output logic tck, // Test clock.
  output logic tms, // Mode select.
  output logic tdi, // Serial data into the device.
  input wire logic tdo // Serial data from the device.
);
  timeunit 1ns;
  timeprecision 1ps;

  integer seed = 32'h1d14;

  // The clock rests low between frames, so the device only sees edges we mean.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One 32 ns test clock; tdo is taken just before the rising edge.
  task automatic tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    #16;
    o = tdo;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask

  // Outside the shift states TDI is random, so the device must not read it there.
  function automatic logic junk();
    logic [31:0] r;
    r = $random(seed);
    return r[0];
  endfunction

  // Stay in run-test/idle so the device can see its acknowledge.
  task automatic idle(input int n);
    logic o;
    logic stay;
    stay = 1'b0;
    repeat (n) tick(stay, junk(), o);
  endtask

  // Scan n bits, first bit first, through the instruction or data path.
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    logic [3:0] lead;
    int nl;
    dout = '0;
    lead = ir ? 4'b0011 : 4'b0001;
    nl = ir ? 4 : 3;
    // From idle: select (twice for the instruction path), capture, shift.
    for (int j = 0; j < nl; j++) begin
      tick(lead[j], junk(), o);
    end
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    // Update, then back to idle.
    for (int j = 0; j < 2; j++) begin
      tick(j == 0, junk(), o);
    end
  endtask
endmodule

// *** verification/eisp_sequencer_bench.sv ***
// Self-checking bench for the serial programming sequencer.
`include "eisp_defs.svh"
module eisp_sequencer_bench;
  import eisp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [31:0] ID = 32'h00c3_5e01; // Arbitrary identity value.
  logic core_clk = 1'b0;
  logic rst_n;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic isp_active;
  logic [`EISP_IO_W-1:0] user_out;
  logic [`EISP_IO_W-1:0] user_oe;
  eisp_pin_type pad;
  int total_checks = 0;
  int n_mismatch = 0;
  integer seed = 32'h1d14;
  logic [15:0] mem [256];
  logic [7:0] vlist [7];
  logic [31:0] dout;

  always #2 core_clk = ~core_clk;

  // Short pulse counts keep the run brief; waits below are sized from them.
  eisp_sequencer #(.ID_CODE(ID), .MODE_CYC(20), .ERASE_CYC(50), .PROG_CYC(10),
                   .READ_CYC(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .user_out(user_out), .user_oe(user_oe),
    .pad(pad), .isp_active(isp_active));

  eisp_host h (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Readback word: zero pad, the address, then the stored data.
  function automatic logic [31:0] rd_word(input logic [7:0] a);
    return {8'h00, a, mem[a]};
  endfunction

  // New random user drive, then the pads must follow the mode.
  task automatic pins(input logic prog);
    @(posedge core_clk);
    user_out <= 8'($random(seed));
    user_oe <= 8'($random(seed));
    repeat (4) @(posedge core_clk);
    chk(isp_active, prog);
    chk(pad.out, user_out);
    chk(pad.oe, prog ? 8'h00 : user_oe);
    chk(pad.pull, prog ? 8'hff : 8'h00);
    chk(tdo_oe, 1'b0);
  endtask

  task automatic ir(input logic [3:0] code);
    h.scan(1'b1, 4, {28'h0, code}, dout);
  endtask

  // Enter programming mode, then read the identity back.
  task automatic enter();
    ir(`EISP_IR_ENTER);
    h.idle(8);
    pins(1'b1);
    ir(`EISP_IR_IDCODE);
    h.scan(1'b0, 32, 32'h0, dout);
    chk(dout, ID);
  endtask

  // Each scan launches a read and returns the one launched before it.
  task automatic verify();
    ir(`EISP_IR_VERIFY);
    h.scan(1'b0, 24, {8'h0, vlist[0], 16'h0}, dout);
    for (int k = 1; k <= 7; k++) begin
      h.idle(4);
      h.scan(1'b0, 24, {8'h0, vlist[k % 7], 16'h0}, dout);
      chk(dout, rd_word(vlist[k - 1]));
    end
  endtask

  // Exit, then allow the pin hand-back before looking at the pads.
  task automatic leave();
    ir(`EISP_IR_EXIT);
    h.idle(8);
    pins(1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] d;
    logic o1;
    rst_n = 1'b0;
    user_out = '0;
    user_oe = '0;
    fork
      repeat (20) @(posedge core_clk);
      h.idle(2);
    join
    rst_n <= 1'b1;
    pins(1'b0);
    // The port wakes in test-logic-reset; one low mode bit brings it to idle.
    h.idle(1);
    h.scan(1'b0, 32, 32'h0, dout);
    chk(dout, ID);
    // Addresses span both ends of the array plus one left erased.
    for (int k = 0; k < 6; k++) begin
      vlist[k] = 8'(k * 51);
    end
    vlist[6] = 8'h07;
    enter();
    ir(`EISP_IR_ERASE);
    h.idle(12);
    for (int a = 0; a < 256; a++) begin
      mem[a] = 16'hffff;
    end
    ir(`EISP_IR_PROG);
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      mem[vlist[k]] = d;
      h.scan(1'b0, 24, {8'h0, vlist[k], d}, dout);
      h.idle(4);
    end
    verify();
    leave();
    // Outside programming mode these must leave the array alone.
    ir(`EISP_IR_PROG);
    h.scan(1'b0, 24, {8'h0, vlist[1], ~mem[vlist[1]]}, dout);
    h.idle(4);
    ir(`EISP_IR_ERASE);
    h.idle(12);
    // Verification-only pass skips erase and program.
    enter();
    verify();
    leave();
    // Any other instruction selects a one-bit bypass: output lags input by one.
    ir(`EISP_IR_BYPASS);
    d = $random(seed);
    h.scan(1'b0, 8, {24'h0, d[7:0]}, dout);
    chk(dout, {24'h0, d[6:0], 1'b0});
    // Five high mode bits reset the port, which reselects the identity path.
    for (int k = 0; k < 5; k++) begin
      h.tick(1'b1, d[k + 8], o1);
    end
    h.idle(1);
    h.scan(1'b0, 32, 32'h0, dout);
    chk(dout, ID);
    test_done();
  end

  // Cuts a hang short and counts it as a mismatch.
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
endmodule
